// ===== rtl/sfiba_pkg.sv
package sfiba_pkg;
	// Link shape: sixteen data lanes plus the sampled forwarded clock.
	localparam int NUM_LANES = 16;
	localparam int LANE_ALL = NUM_LANES + 1;
	localparam int CLK_LANE = NUM_LANES;
	localparam int DESER = 4;
	localparam int WORD_W = NUM_LANES * DESER;

	// Shared delay line.
	localparam int TAP_W = 4;
	localparam int NUM_TAPS = 16;
	localparam logic [TAP_W-1:0] TAP_RESET = 4'h0;
	localparam logic [TAP_W-1:0] TAP_STEP = 4'h1;

	// Deserializer bit counter.
	localparam logic [1:0] BIT_LAST = 2'h3;
	localparam logic [1:0] BIT_STEP = 2'h1;

	// Training timing, counted in deserialized words.
	localparam logic [2:0] SETTLE_WORDS = 3'h2;
	localparam logic [2:0] CONFIRM_LAST = 3'h3;
	localparam logic [2:0] CNT_STEP = 3'h1;

	// Word alignment marker expected on lane 0, and the sampled clock word patterns.
	localparam logic [DESER-1:0] TRAIN_NIBBLE = 4'h8;
	localparam logic [DESER-1:0] NIB_ONES = 4'hf;
	localparam logic [DESER-1:0] NIB_ZEROS = 4'h0;

	// Training sequence.
	typedef enum logic [2:0] {
		ST_START,
		ST_SEEK_ONE,
		ST_SEEK_FALL,
		ST_WORD_SEARCH,
		ST_WORD_CONFIRM,
		ST_ALIGNED
	} sfiba_state_t;
endpackage

// ===== rtl/sfiba_delay_mem.sv
`timescale 1ns/10ps
module sfiba_delay_mem
(
	// Clock and reset.
	input wire logic clk,
	input wire logic rstn,
	// Samples in and delay selection.
	input wire logic [sfiba_pkg::LANE_ALL-1:0] din,
	input wire logic [sfiba_pkg::TAP_W-1:0] tap,
	// Delayed samples, registered.
	output logic [sfiba_pkg::LANE_ALL-1:0] dout
);
	import sfiba_pkg::*;

	typedef struct packed {
		logic [NUM_TAPS-1:0][LANE_ALL-1:0] line;
		logic [LANE_ALL-1:0] dout;
	} sfiba_dly_t;

	sfiba_dly_t q;
	sfiba_dly_t d;

	// One tap is one core cycle; all lanes share the same selected tap.
	always_comb
	begin
		d = q;
		d.line = {q.line[NUM_TAPS-2:0], din};
		d.dout = q.line[tap];
	end

	// State register.
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			q <= '0;
		else
			q <= d;
	end

	assign dout = q.dout;
endmodule

// ===== rtl/sfiba_rx.sv
`timescale 1ns/10ps
// Overview of operation
// - Link carries sixteen data lanes plus one forwarded clock.
// - Each lane deserialized four to one into a 64-bit word.
// - All lanes share one delay setting; inter-lane skew assumed small.
// - Forwarded clock is deserialized exactly like an extra data lane.
// - Step shared delay until sampled clock falls, then hold it.
// - Training works from a sampled clock of one, zero or ambiguous.
// - A start from a sampled clock other than one steps the tap until it samples ones.
// - Word alignment starts only after bus alignment, in same machine.
// - Signals to the tester cross asynchronous domains safely.
// - Tester generates patterns and checks received data for accuracy.
module sfiba_rx
(
	// Clock and reset.
	input wire logic clk,
	input wire logic rstn,
	// Link pins.
	input wire logic [sfiba_pkg::NUM_LANES-1:0] lane_din,
	input wire logic link_clk,
	// Received words towards the pattern checker.
	output logic [sfiba_pkg::WORD_W-1:0] rx_data_q,
	output logic rx_word_toggle_q,
	output logic rx_aligned_q,
	// Training status.
	output logic bus_aligned_q,
	output logic [sfiba_pkg::TAP_W-1:0] delay_tap_q,
	output logic [sfiba_pkg::DESER-1:0] clk_word_q
);
	import sfiba_pkg::*;

	typedef struct packed {
		logic [LANE_ALL-1:0] sync1;
		logic [LANE_ALL-1:0] sync2;
		logic clk_prev;
		logic [LANE_ALL-1:0][DESER-1:0] shreg;
		logic [1:0] bit_cnt;
		logic slip;
		logic word_rdy;
		logic [LANE_ALL-1:0][DESER-1:0] word;
		sfiba_state_t state;
		logic [2:0] settle;
		logic [2:0] confirm;
		logic [TAP_W-1:0] tap;
		logic bus_aligned;
		logic aligned;
		logic toggle;
		logic [WORD_W-1:0] data;
	} sfiba_rx_t;

	sfiba_rx_t q;
	sfiba_rx_t d;
	logic [LANE_ALL-1:0] dly_out;
	logic [DESER-1:0] cw;
	logic [DESER-1:0] lane0;

	// Next tap wraps so a search that misses the edge keeps going.
	function automatic logic [TAP_W-1:0] next_tap(input logic [TAP_W-1:0] t);
		next_tap = t + TAP_STEP;
	endfunction

	// Flatten the data lanes, lane 0 in the low nibble.
	function automatic logic [WORD_W-1:0] flat(
		input logic [LANE_ALL-1:0][DESER-1:0] w);
		logic [WORD_W-1:0] r;
		r = '0;
		for (int i = 0; i < NUM_LANES; i++)
			r[i*DESER +: DESER] = w[i];
		flat = r;
	endfunction

	// The forwarded clock rides through the delay line as lane 16.
	sfiba_delay_mem u_delay
	(
		.clk(clk),
		.rstn(rstn),
		.din(q.sync2),
		.tap(q.tap),
		.dout(dly_out)
	);

	assign cw = q.word[CLK_LANE];
	assign lane0 = q.word[0];

	// Sampling, deserializing and the training sequence.
	always_comb
	begin
		d = q;
		d.sync1 = {link_clk, lane_din};
		d.sync2 = q.sync1;
		d.clk_prev = q.sync2[CLK_LANE];
		d.word_rdy = 1'b0;
		// The undelayed clock rise is the fixed strobe; delay moves the eye.
		if (q.sync2[CLK_LANE] && !q.clk_prev)
		begin
			for (int i = 0; i < LANE_ALL; i++)
				d.shreg[i] = {q.shreg[i][DESER-2:0], dly_out[i]};
			if (q.slip)
				d.slip = 1'b0;
			else if (q.bit_cnt == BIT_LAST)
			begin
				d.bit_cnt = '0;
				d.word = d.shreg;
				d.word_rdy = 1'b1;
			end
			else
				d.bit_cnt = q.bit_cnt + BIT_STEP;
		end
		// Decisions are made once per word, after the delay has settled.
		if (q.word_rdy)
		begin
			d.data = flat(q.word);
			if (q.settle != '0)
				d.settle = q.settle - CNT_STEP;
			else
			begin
				case (q.state)
					ST_START:
					begin
						if (cw == NIB_ONES)
							d.state = ST_SEEK_FALL;
						else
						begin
							d.state = ST_SEEK_ONE;
							d.tap = next_tap(q.tap);
							d.settle = SETTLE_WORDS;
						end
					end
					ST_SEEK_ONE:
					begin
						if (cw == NIB_ONES)
							d.state = ST_SEEK_FALL;
						else
						begin
							d.tap = next_tap(q.tap);
							d.settle = SETTLE_WORDS;
						end
					end
					ST_SEEK_FALL:
					begin
						if (cw == NIB_ZEROS)
						begin
							d.state = ST_WORD_SEARCH;
							d.bus_aligned = 1'b1;
						end
						else
						begin
							d.tap = next_tap(q.tap);
							d.settle = SETTLE_WORDS;
						end
					end
					ST_WORD_SEARCH:
					begin
						if (lane0 == TRAIN_NIBBLE)
						begin
							d.state = ST_WORD_CONFIRM;
							d.confirm = '0;
						end
						else
						begin
							d.slip = 1'b1;
							d.settle = SETTLE_WORDS;
						end
					end
					ST_WORD_CONFIRM:
					begin
						// A lost marker restarts the search without a slip.
						if (lane0 != TRAIN_NIBBLE)
							d.state = ST_WORD_SEARCH;
						else if (q.confirm == CONFIRM_LAST)
						begin
							d.state = ST_ALIGNED;
							d.aligned = 1'b1;
						end
						else
							d.confirm = q.confirm + CNT_STEP;
					end
					ST_ALIGNED:
					begin
						// The word and the toggle change in one cycle and
						// then stand for a whole word, so the far domain
						// synchronises the toggle alone before reading.
						d.toggle = ~q.toggle;
					end
					default:
						d.state = ST_START;
				endcase
			end
		end
		// Data stays zero until the link is aligned.
		if (!d.aligned)
			d.data = '0;
	end

	// State register; the tap and status reset to known values.
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			q <= '0;
			q.state <= ST_START;
			q.tap <= TAP_RESET;
			// Words built from the empty delay line are never judged.
			q.settle <= SETTLE_WORDS;
		end
		else
			q <= d;
	end

	// Outputs come straight from the state register. The wide word never
	// crosses on its own: the tester waits for a synchronised toggle
	// change, and the word stands unchanged for a whole word time.
	assign rx_data_q = q.data;
	assign rx_word_toggle_q = q.toggle;
	assign rx_aligned_q = q.aligned;
	assign bus_aligned_q = q.bus_aligned;
	assign delay_tap_q = q.tap;
	assign clk_word_q = cw;
endmodule

// ===== tb/sfiba_chk_assertions.sv
`timescale 1ns/10ps
module sfiba_chk
	import sfiba_pkg::*;
(
	// Watched outputs with their clock and reset.
	input wire logic clk,
	input wire logic rstn,
	input wire logic [WORD_W-1:0] rx_data_q,
	input wire logic rx_word_toggle_q,
	input wire logic rx_aligned_q,
	input wire logic bus_aligned_q,
	input wire logic [TAP_W-1:0] delay_tap_q,
	input wire logic [DESER-1:0] clk_word_q
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	// Nothing reaches the tester before both alignments are done.
	property p_z; !rx_aligned_q |-> rx_data_q == '0; endproperty
	a_z: assert property (p_z) else $error("data early");
	property p_t; !rx_aligned_q |=> $stable(rx_word_toggle_q); endproperty
	a_t: assert property (p_t) else $error("toggle early");
	property p_o; rx_aligned_q |-> bus_aligned_q; endproperty
	a_o: assert property (p_o) else $error("word before bus");
	property p_s; rx_aligned_q |=> rx_aligned_q; endproperty
	a_s: assert property (p_s) else $error("aligned lost");
	// The tap found at the falling edge is the one kept for all lanes.
	property p_h; bus_aligned_q |=> $stable(delay_tap_q); endproperty
	a_h: assert property (p_h) else $error("tap moved");
	property p_f; $rose(bus_aligned_q) |-> clk_word_q == NIB_ZEROS; endproperty
	a_f: assert property (p_f) else $error("no fall");
	property p_p; $changed(delay_tap_q) |-> delay_tap_q ==
		$past(delay_tap_q) + TAP_STEP; endproperty
	a_p: assert property (p_p) else $error("tap jump");
	// A word takes four link periods of eight core cycles.
	property p_w; $changed(rx_word_toggle_q) |=>
		$stable(rx_word_toggle_q)[*8]; endproperty
	a_w: assert property (p_w) else $error("word rate");
	c_b: cover property ($rose(bus_aligned_q));
	c_a: cover property ($rose(rx_aligned_q));
	c_t: cover property ($changed(delay_tap_q));
endmodule
bind sfiba_rx sfiba_chk u_chk (.clk(clk), .rstn(rstn),
	.rx_data_q(rx_data_q), .rx_word_toggle_q(rx_word_toggle_q),
	.rx_aligned_q(rx_aligned_q), .bus_aligned_q(bus_aligned_q),
	.delay_tap_q(delay_tap_q), .clk_word_q(clk_word_q));

// ===== tb/sfiba_link_model.sv
`timescale 1ns/10ps
module sfiba_link_model
(
	// Frame control.
	input wire logic en,
	input wire logic [9:0] ph,
	input wire logic [9:0] hi,
	// Link pins.
	output logic [15:0] lane_din,
	output logic link_clk
);
	int b;
	// Clock stands low between frames; data moves on its rising edge.
	// The high time sets the sampled clock value that training starts
	// from, while the period stays at 800 ns.
	initial
	begin
		link_clk = 1'b0;
		lane_din = 16'h0;
		b = 0;
		forever
		begin
			wait (en);
			#(ph);
			while (en)
			begin
				// Lane 0 carries the marker, lane i the value i, MSB first.
				for (int i = 0; i < 16; i++)
					lane_din[i] = (i == 0) ? (b == 0) : i[3 - b];
				b = (b + 1) % 4;
				link_clk = 1'b1;
				#(hi);
				link_clk = 1'b0;
				#(10'h320 - hi);
			end
		end
	end
endmodule

// ===== tb/tb.sv
`timescale 1ns/10ps
module tb;
	import sfiba_pkg::*;
	localparam logic [63:0] EXP = 64'hfedcba9876543218;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic en = 1'b0;
	// Link edges sit between core clock edges so no sample races them.
	logic [9:0] ph = 10'h1e;
	// Forwarded clock high time in ns.
	logic [9:0] hi = 10'h190;
	logic [NUM_LANES-1:0] lane_din;
	logic link_clk;
	logic [WORD_W-1:0] rx_data_q;
	logic rx_word_toggle_q;
	logic rx_aligned_q;
	logic bus_aligned_q;
	logic [TAP_W-1:0] delay_tap_q;
	logic [DESER-1:0] clk_word_q;
	int bad_count = 0;
	int cmp_count = 0;
	// Core clock.
	always #50 clk = ~clk;
	sfiba_link_model u_link (.en(en), .ph(ph), .hi(hi), .lane_din(lane_din),
		.link_clk(link_clk));
	sfiba_rx u_dut (.clk(clk), .rstn(rstn), .lane_din(lane_din),
		.link_clk(link_clk), .rx_data_q(rx_data_q),
		.rx_word_toggle_q(rx_word_toggle_q), .rx_aligned_q(rx_aligned_q),
		.bus_aligned_q(bus_aligned_q), .delay_tap_q(delay_tap_q),
		.clk_word_q(clk_word_q));
	task chk(input string nm, input logic [63:0] e, input logic [63:0] g);
		cmp_count++;
		if (g !== e)
		begin
			bad_count++;
			$display("mismatch %s exp %h got %h", nm, e, g);
		end
	endtask
	task give_verdict;
		$display("checks %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// Training from either start must end on the falling edge; a clock
	// that samples as one must show ones before any tap step.
	task t_train(input logic one_start);
		int n;
		logic seen;
		logic [TAP_W-1:0] tap_at_ones;
		n = 0;
		seen = 1'b0;
		tap_at_ones = '0;
		while (rx_aligned_q !== 1'b1 && n < 20000)
		begin
			@(posedge clk);
			#1;
			if (!seen && clk_word_q === NIB_ONES)
			begin
				seen = 1'b1;
				tap_at_ones = delay_tap_q;
			end
			n++;
		end
		chk("aligned", 1, rx_aligned_q);
		chk("bus", 1, bus_aligned_q);
		chk("clkword", 0, clk_word_q);
		chk("ones", 1, seen);
		chk("nostep", one_start, tap_at_ones === TAP_RESET);
	endtask
	// Ten words in 320 cycles; the last one is checked for every lane in place.
	task t_rate;
		int c;
		logic t;
		c = 0;
		t = rx_word_toggle_q;
		repeat (320)
		begin
			@(posedge clk);
			#1;
			if (rx_word_toggle_q !== t)
				c++;
			t = rx_word_toggle_q;
		end
		chk("words", 10, c);
		chk("data", EXP, rx_data_q);
	endtask
	// Reset clears status, tap and data; the link restarts at a new phase and the given high time.
	task t_reset(input logic [9:0] h);
		@(posedge clk);
		rstn <= 1'b0;
		en <= 1'b0;
		repeat (10) @(posedge clk);
		#1;
		chk("rst", 0, {rx_aligned_q, bus_aligned_q, delay_tap_q});
		chk("rstdata", 0, rx_data_q);
		@(posedge clk);
		ph <= ph + 10'h12c;
		hi <= h;
		rstn <= 1'b1;
		en <= 1'b1;
	endtask
	initial
	begin
		repeat (10) @(posedge clk);
		rstn <= 1'b1;
		en <= 1'b1;
		t_train(1'b0);
		t_rate();
		t_reset(10'h190);
		repeat (300) @(posedge clk);
		t_reset(10'h2bc);
		t_train(1'b1);
		t_rate();
		give_verdict();
	end
	// Watchdog.
	initial
	begin
		#8000000;
		bad_count++;
		give_verdict();
	end
endmodule
